// file: core/tsc_pkg.sv
/*
 package of the touch converter scan-mode control: register layout, mode codes,
 interrupt-select codes and the channel type.
 assumes nothing of its surroundings; imported whole by every module of the block.
*/
package tsc_pkg;
    localparam int          CTRL_W      = 8;
    localparam int          SELF_BIT    = 7;
    localparam int          RSVD_BIT    = 6;
    localparam int          MODE_HI     = 5;
    localparam int          MODE_LO     = 2;
    localparam int          IRQ_HI      = 1;
    localparam int          IRQ_LO      = 0;
    localparam logic [7:0]  CTRL_RESET  = 8'h00;
    localparam logic [7:0]  RSVD_MASK   = 8'h40;
    localparam int          SEQ_SLOTS   = 4;

    typedef logic [3:0] tsc_mode_t;
    localparam tsc_mode_t MODE_NONE  = 4'h0;
    localparam tsc_mode_t MODE_XY    = 4'h1;
    localparam tsc_mode_t MODE_XYZ   = 4'h2;
    localparam tsc_mode_t MODE_X     = 4'h3;
    localparam tsc_mode_t MODE_Y     = 4'h4;
    localparam tsc_mode_t MODE_PRESS = 4'h5;
    // defaults only; these codes are not settled
    localparam tsc_mode_t MODE_AUX_INPUT_ONE_DEF  = 4'h6;
    localparam tsc_mode_t MODE_AUX_INPUT_TWO_DEF  = 4'h7;
    localparam tsc_mode_t MODE_VBAT_DEF  = 4'h8;
    localparam tsc_mode_t MODE_AUTO_DEF  = 4'h9;
    localparam tsc_mode_t MODE_TEMP_SENSE_ONE_DEF = 4'ha;
    localparam tsc_mode_t MODE_TEMP_SENSE_TWO_DEF = 4'hb;

    typedef logic [1:0] tsc_irq_sel_t;
    localparam tsc_irq_sel_t IRQ_PEN   = 2'h0;
    localparam tsc_irq_sel_t IRQ_READY = 2'h1;
    localparam tsc_irq_sel_t IRQ_BOTH  = 2'h2;

    // order matters: slot index maps straight onto the X,Y,pressure scan
    typedef enum logic [3:0] {
        CH_X, CH_Y, CH_PRESS_A, CH_PRESS_B, CH_AUX_ONE, CH_AUX_TWO, CH_VBAT, CH_TEMP_ONE, CH_TEMP_TWO
    } tsc_chan_t;
endpackage

// file: core/tsc_irq_if.sv
/*
 interface carrying pen and result-ready indications and the interrupt select
 to the interrupt shaper, and the shaped pin level back.
 assumes one clock domain on both sides.
*/
`timescale 1ns/1ps
interface tsc_irq_if;
    import tsc_pkg::*;
    logic         pen_touch;
    logic         result_ready;
    tsc_irq_sel_t irq_sel;
    logic         irq_level;
    modport src (output pen_touch, output result_ready, output irq_sel, input irq_level);
    modport shp (input pen_touch, input result_ready, input irq_sel, output irq_level);
endinterface

// file: core/tsc_irq_shape.sv
/*
 interrupt shaper: turns pen-touch and result-ready into the shared pin level.
 assumes its inputs are already on the block clock.
*/
`timescale 1ns/1ps
module tsc_irq_shape
    import tsc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst,
    tsc_irq_if.shp    irq
);
    always_ff @(posedge clock) begin
        if (rst) begin
            irq.irq_level <= 1'b1;
        end else begin
            case (irq.irq_sel)
                IRQ_PEN:   irq.irq_level <= ~irq.pen_touch;
                IRQ_READY: irq.irq_level <= ~irq.result_ready;
                IRQ_BOTH:  irq.irq_level <= irq.pen_touch | irq.result_ready;
                default:   irq.irq_level <= ~irq.pen_touch;
            endcase
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    pen_low_a: assert property (
        irq.irq_sel == IRQ_PEN |=> irq.irq_level == ~$past(irq.pen_touch))
        else $error("pen interrupt level wrong");
    ready_low_a: assert property (
        irq.irq_sel == IRQ_READY && irq.result_ready |=> !irq.irq_level)
        else $error("result-ready interrupt not low");
    both_high_a: assert property (
        irq.irq_sel == IRQ_BOTH && !irq.pen_touch && !irq.result_ready |=> !irq.irq_level)
        else $error("combined interrupt high without cause");
    both_cv: cover property (irq.irq_sel == IRQ_BOTH && irq.pen_touch ##1 irq.irq_level);
endmodule

// file: core/tsc_scan_ctrl.sv
/*
 touch converter scan-mode control: control register, scan sequencer and
 result-ready flag; drives the converter start/channel and the interrupt pin.
 assumes the stop bit, start request, conversion-done and input enables come
 from logic on the same clock; only the pen comparator is asynchronous.
*/
`timescale 1ns/1ps
module tsc_scan_ctrl
    import tsc_pkg::*;
#(
    parameter tsc_mode_t MODE_AUX_INPUT_ONE  = MODE_AUX_INPUT_ONE_DEF,
    parameter tsc_mode_t MODE_AUX_INPUT_TWO  = MODE_AUX_INPUT_TWO_DEF,
    parameter tsc_mode_t MODE_VBAT  = MODE_VBAT_DEF,
    parameter tsc_mode_t MODE_AUTO  = MODE_AUTO_DEF,
    parameter tsc_mode_t MODE_TEMP_SENSE_ONE = MODE_TEMP_SENSE_ONE_DEF,
    parameter tsc_mode_t MODE_TEMP_SENSE_TWO = MODE_TEMP_SENSE_TWO_DEF
) (
    input  wire logic              clock,
    input  wire logic              rst,
    input  wire logic              reg_wr,
    input  wire logic [CTRL_W-1:0] reg_wdata,
    output logic      [CTRL_W-1:0] reg_rdata,
    input  wire logic              sar_stop,
    input  wire logic              host_start,
    input  wire logic              pen_down_pin,
    input  wire logic              conv_done,
    input  wire logic              result_read,
    input  wire logic              aux_input_one_en,
    input  wire logic              aux_input_two_en,
    input  wire logic              vbat_en,
    output logic                   conv_start,
    output tsc_chan_t              conv_chan,
    output logic                   scan_busy,
    output logic                   adc_power_down,
    output logic                   irq_pin
);
    typedef enum logic {ST_IDLE, ST_CONV} tsc_state_t;

    generate
        if (MODE_AUX_INPUT_ONE <= MODE_PRESS || MODE_AUX_INPUT_TWO <= MODE_PRESS || MODE_VBAT <= MODE_PRESS ||
            MODE_AUTO <= MODE_PRESS || MODE_TEMP_SENSE_ONE <= MODE_PRESS || MODE_TEMP_SENSE_TWO <= MODE_PRESS) begin : g_bad
            $error("measurement mode code overlaps a touch mode");
        end
    endgenerate

    logic [CTRL_W-1:0] ctrl_reg;
    logic [CTRL_W-1:0] reg_rdata_reg;
    logic              pen_meta_reg;
    logic              pen_sync_reg;
    tsc_state_t        state_reg;
    tsc_mode_t         mode_reg;
    logic [1:0]        slot_reg;
    tsc_chan_t         chan_reg;
    logic              start_reg;
    logic              busy_reg;
    logic              pdown_reg;
    logic              ready_reg;
    tsc_mode_t         mode_field;
    logic              self_ctrl;
    logic [2:0]        en;
    logic [2:0]        first_slot;
    logic [4:0]        first_ent;
    logic [2:0]        next_slot;
    logic [4:0]        next_ent;
    logic              wrapped;
    logic              touch_mode;
    logic              self_only;
    logic              go;
    logic              again;
    tsc_irq_if         irq_bus ();

    assign mode_field = ctrl_reg[MODE_HI:MODE_LO];
    assign self_ctrl  = ctrl_reg[SELF_BIT];
    assign en         = {vbat_en, aux_input_two_en, aux_input_one_en};

    // {valid, channel} for one slot of a mode's sequence
    function automatic logic [4:0] seq_entry(tsc_mode_t m, logic [1:0] i, logic [2:0] e);
        logic      v;
        tsc_chan_t c;
        v = 1'b0;
        c = CH_X;
        if (m == MODE_XY) begin
            v = (i < 2'h2);
            c = (i == 2'h0) ? CH_X : CH_Y;
        end else if (m == MODE_XYZ) begin
            v = 1'b1;
            c = tsc_chan_t'({2'h0, i});
        end else if (m == MODE_X) begin
            v = (i == 2'h0);
            c = CH_X;
        end else if (m == MODE_Y) begin
            v = (i == 2'h0);
            c = CH_Y;
        end else if (m == MODE_PRESS) begin
            v = (i < 2'h2);
            c = (i == 2'h0) ? CH_PRESS_A : CH_PRESS_B;
        end else if (m == MODE_AUTO) begin
            v = (i < 2'h3) && e[i];
            c = (i == 2'h0) ? CH_AUX_ONE : (i == 2'h1) ? CH_AUX_TWO : CH_VBAT;
        end else if (m == MODE_AUX_INPUT_ONE || m == MODE_AUX_INPUT_TWO || m == MODE_VBAT ||
                     m == MODE_TEMP_SENSE_ONE || m == MODE_TEMP_SENSE_TWO) begin
            v = (i == 2'h0);
            c = (m == MODE_AUX_INPUT_ONE) ? CH_AUX_ONE : (m == MODE_AUX_INPUT_TWO) ? CH_AUX_TWO :
                (m == MODE_VBAT) ? CH_VBAT : (m == MODE_TEMP_SENSE_ONE) ? CH_TEMP_ONE : CH_TEMP_TWO;
        end
        return {v, 4'(c)};
    endfunction

    // first valid slot at or after s, cyclically; disabled inputs are skipped in auto-scan only
    function automatic logic [2:0] find_slot(tsc_mode_t m, logic [1:0] s, logic [2:0] e);
        logic [1:0] j;
        logic [4:0] ent;
        logic [2:0] r;
        r = 3'h0;
        for (int k = SEQ_SLOTS - 1; k >= 0; k--) begin
            j   = s + 2'(k);
            ent = seq_entry(m, j, e);
            if (ent[4]) begin
                r = {1'b1, j};
            end
        end
        return r;
    endfunction

    always_comb begin
        first_slot = find_slot(mode_field, 2'h0, en);
        first_ent  = seq_entry(mode_field, first_slot[1:0], en);
        next_slot  = find_slot(mode_reg, slot_reg + 2'h1, en);
        next_ent   = seq_entry(mode_reg, next_slot[1:0], en);
        wrapped    = next_slot[1:0] <= slot_reg;
        touch_mode = (mode_field >= MODE_XY) && (mode_field <= MODE_PRESS);
        self_only  = (mode_field >= MODE_X) && (mode_field <= MODE_PRESS);
    end

    // self-controlled: pen starts touch scans; host start otherwise, but X, Y and pressure scans start only when self-controlled
    assign go = !sar_stop && mode_field != MODE_NONE && first_slot[2] &&
                (touch_mode ? (self_ctrl ? pen_sync_reg : (host_start && !self_only))
                            : host_start);
    // touch scans loop while the pen stays down; auto loops regardless
    assign again = ((mode_reg >= MODE_XY) && (mode_reg <= MODE_PRESS) && pen_sync_reg) ||
                   (mode_reg == MODE_AUTO);

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
        end else if (reg_wr) begin
            ctrl_reg <= reg_wdata & ~RSVD_MASK;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_reg <= CTRL_RESET;
        end else begin
            reg_rdata_reg <= ctrl_reg;
        end
    end

    // pen comparator is asynchronous to the block clock
    always_ff @(posedge clock) begin
        if (rst) begin
            pen_meta_reg <= 1'b0;
            pen_sync_reg <= 1'b0;
        end else begin
            pen_meta_reg <= pen_down_pin;
            pen_sync_reg <= pen_meta_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            mode_reg  <= MODE_NONE;
            slot_reg  <= 2'h0;
            chan_reg  <= CH_X;
            start_reg <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (go) begin
                        state_reg <= ST_CONV;
                        mode_reg  <= mode_field;
                        slot_reg  <= first_slot[1:0];
                        chan_reg  <= tsc_chan_t'(first_ent[3:0]);
                        start_reg <= 1'b1;
                        busy_reg  <= 1'b1;
                    end
                end
                ST_CONV: begin
                    // a change of the mode field ends the scan too
                    if (sar_stop || mode_field != mode_reg) begin
                        state_reg <= ST_IDLE;
                        busy_reg  <= 1'b0;
                    end else if (conv_done) begin
                        if (next_slot[2] && (!wrapped || again)) begin
                            slot_reg  <= next_slot[1:0];
                            chan_reg  <= tsc_chan_t'(next_ent[3:0]);
                            start_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                            busy_reg  <= 1'b0;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pdown_reg <= 1'b1;
        end else begin
            pdown_reg <= sar_stop;
        end
    end

    // new result sets the flag even in the cycle it is read
    always_ff @(posedge clock) begin
        if (rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= (state_reg == ST_CONV && conv_done) | (ready_reg & ~result_read);
        end
    end

    assign irq_bus.pen_touch    = pen_sync_reg;
    assign irq_bus.result_ready = ready_reg;
    assign irq_bus.irq_sel      = ctrl_reg[IRQ_HI:IRQ_LO];

    tsc_irq_shape u_shape (
        .clock (clock),
        .rst   (rst),
        .irq   (irq_bus.shp)
    );

    assign reg_rdata      = reg_rdata_reg;
    assign conv_start     = start_reg;
    assign conv_chan      = chan_reg;
    assign scan_busy      = busy_reg;
    assign adc_power_down = pdown_reg;
    assign irq_pin        = irq_bus.irq_level;

    default clocking @(posedge clock); endclocking
    default disable iff (rst);

    stop_halts_a: assert property (sar_stop |=> !scan_busy && !conv_start)
        else $error("scan still running after stop");
    no_scan_a: assert property (mode_field == MODE_NONE |=> !conv_start)
        else $error("conversion started in no-scan mode");
    host_wait_a: assert property (
        state_reg == ST_IDLE && !self_ctrl && !host_start |=> !conv_start)
        else $error("host mode started without request");
    self_only_a: assert property (
        state_reg == ST_IDLE && !self_ctrl && mode_field >= MODE_X && mode_field <= MODE_PRESS |=> !conv_start)
        else $error("self-only scan started under host control");
    xy_order_a: assert property (
        state_reg == ST_CONV && conv_done && !sar_stop && mode_field == mode_reg && mode_reg == MODE_XY &&
        chan_reg == CH_X |=> conv_start && conv_chan == CH_Y)
        else $error("Y did not follow X");
    press_order_a: assert property (
        state_reg == ST_CONV && conv_done && !sar_stop && mode_field == mode_reg && mode_reg == MODE_XYZ &&
        chan_reg == CH_PRESS_A |=> conv_start && conv_chan == CH_PRESS_B)
        else $error("second pressure sample skipped");
    pen_lift_a: assert property (
        state_reg == ST_CONV && conv_done && mode_reg == MODE_XY && chan_reg == CH_Y && !pen_sync_reg
        |=> !scan_busy ##1 !conv_start)
        else $error("scan repeated after pen lift");
    auto_loop_a: assert property (
        state_reg == ST_CONV && conv_done && !sar_stop && mode_field == mode_reg && mode_reg == MODE_AUTO &&
        chan_reg == CH_VBAT && aux_input_one_en |=> conv_start && conv_chan == CH_AUX_ONE)
        else $error("auto scan did not loop");
    single_once_a: assert property (
        state_reg == ST_CONV && conv_done && mode_reg == MODE_AUX_INPUT_TWO |=> !scan_busy)
        else $error("single measurement repeated");
    rsvd_zero_a: assert property (reg_wr |-> ##2 !reg_rdata[RSVD_BIT])
        else $error("reserved bit reads as one");

    xy_repeat_cv: cover property (conv_chan == CH_Y && conv_done ##1 conv_start && conv_chan == CH_X);
    auto_cv: cover property (conv_start && conv_chan == CH_VBAT);
    stop_cv: cover property (scan_busy && sar_stop ##1 !scan_busy);
endmodule

// file: verif/tsc_panel_model.sv
/*
 behavioural touch panel and converter as seen from the scan control.
 assumes conv_start is a one-cycle pulse on the same clock as the block.
*/
`timescale 1ns/1ps
module tsc_panel_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       touch,
    input  wire logic [7:0] lift_after,
    input  wire logic [3:0] conv_lat,
    input  wire logic       conv_start,
    output logic            pen_down_pin,
    output logic            conv_done
);
    logic [7:0] done_cnt_reg;
    logic [3:0] wait_reg;
    logic       active_reg;

    // pen lifts after a set count of conversions, so a lift can land mid-pass
    assign pen_down_pin = touch && (lift_after == 8'h00 || done_cnt_reg < lift_after);

    // conversion time set by the bench: short or slow
    always_ff @(posedge clock) begin
        conv_done <= 1'b0;
        if (rst) begin
            active_reg <= 1'b0;
            wait_reg   <= 4'h0;
        end else if (conv_start) begin
            active_reg <= 1'b1;
            wait_reg   <= conv_lat;
        end else if (active_reg) begin
            if (wait_reg == 4'h0) begin
                conv_done  <= 1'b1;
                active_reg <= 1'b0;
            end else begin
                wait_reg <= wait_reg - 4'h1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst || !touch) begin
            done_cnt_reg <= 8'h00;
        end else if (conv_done) begin
            done_cnt_reg <= done_cnt_reg + 8'h01;
        end
    end
endmodule

// file: verif/tb_tsc_scan_ctrl.sv
/*
 testbench of the touch converter scan-mode control: scans, measurements,
 stop, interrupt select.
 assumes the panel model in tsc_panel_model and the default mode codes.
*/
`timescale 1ns/1ps
module tb_tsc_scan_ctrl
    import tsc_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        reg_wr = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        sar_stop = 1'b0;
    logic        host_start = 1'b0;
    logic        result_read = 1'b0;
    logic        aux_input_one_en = 1'b1;
    logic        aux_input_two_en = 1'b1;
    logic        vbat_en = 1'b1;
    logic        touch = 1'b0;
    logic [7:0]  lift_after = 8'h00;
    logic [3:0]  conv_lat = 4'h2;
    logic [7:0]  reg_rdata;
    logic        pen_down_pin;
    logic        conv_done;
    logic        conv_start;
    tsc_chan_t   conv_chan;
    logic        scan_busy;
    logic        adc_power_down;
    logic        irq_pin;
    int          n_fail = 0;
    int          checks_done = 0;
    tsc_chan_t   seen[$];

    always #2.5 clock = ~clock;

    always @(posedge clock) begin
        if (conv_start === 1'b1) begin
            seen.push_back(conv_chan);
        end
    end

    tsc_scan_ctrl tsc_scan_ctrl_inst (
        .clock(clock), .rst(rst), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sar_stop(sar_stop), .host_start(host_start), .pen_down_pin(pen_down_pin), .conv_done(conv_done),
        .result_read(result_read), .aux_input_one_en(aux_input_one_en), .aux_input_two_en(aux_input_two_en),
        .vbat_en(vbat_en), .conv_start(conv_start), .conv_chan(conv_chan), .scan_busy(scan_busy),
        .adc_power_down(adc_power_down), .irq_pin(irq_pin)
    );

    tsc_panel_model tsc_panel_model_inst (
        .clock(clock), .rst(rst), .touch(touch), .lift_after(lift_after), .conv_lat(conv_lat),
        .conv_start(conv_start), .pen_down_pin(pen_down_pin), .conv_done(conv_done)
    );

    task test_done;
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic pulse(ref logic s);
        @(negedge clock);
        s = 1'b1;
        @(negedge clock);
        s = 1'b0;
    endtask

    task wreg(input logic [7:0] v);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_wdata = v;
        @(negedge clock);
        reg_wr = 1'b0;
        @(negedge clock);
        chk(reg_rdata, v & ~RSVD_MASK);
    endtask

    // bounded wait for the sequence to end
    task wait_idle;
        int k;
        k = 0;
        cyc(6);
        while (scan_busy !== 1'b0 && k < 400) begin
            cyc(1);
            k++;
        end
        if (k >= 400) begin
            n_fail++;
            test_done;
        end
    endtask

    // chans: one nibble per expected conversion, first in the low nibble
    task scan(input logic [7:0] ctrl, input logic hs, input logic [7:0] lift, input int n,
              input logic [31:0] chans);
        int i;
        seen.delete();
        wreg(ctrl);
        lift_after = lift;
        touch = (lift != 8'h00);
        if (hs) pulse(host_start);
        wait_idle;
        touch = 1'b0;
        cyc(2);
        chk(8'(seen.size()), 8'(n));
        for (i = 0; i < n && i < seen.size(); i++) begin
            chk({4'h0, seen[i]}, {4'h0, chans[4*i+:4]});
        end
    endtask

    initial begin
        int k;
        cyc(5);
        chk(reg_rdata, 8'h00);
        chk({7'h0, adc_power_down}, 8'h01);
        chk({7'h0, irq_pin}, 8'h01);
        chk({7'h0, scan_busy}, 8'h00);
        rst = 1'b0;
        scan(8'h00, 1'b1, 8'h00, 0, 32'h0);
        scan(8'h80, 1'b0, 8'h02, 0, 32'h0);
        scan(8'h04, 1'b1, 8'h03, 4, 32'h1010);
        scan(8'h08, 1'b1, 8'h03, 4, 32'h3210);
        scan(8'h0c, 1'b1, 8'h03, 0, 32'h0);
        scan(8'h8c, 1'b0, 8'h03, 4, 32'h0);
        scan(8'h10, 1'b1, 8'h03, 0, 32'h0);
        scan(8'h90, 1'b0, 8'h02, 3, 32'h111);
        scan(8'h14, 1'b1, 8'h03, 0, 32'h0);
        scan(8'h94, 1'b0, 8'h02, 4, 32'h3232);
        scan(8'h84, 1'b0, 8'h02, 4, 32'h1010);
        scan(8'h04, 1'b0, 8'h09, 0, 32'h0);
        scan(8'h1c, 1'b1, 8'h00, 1, 32'h5);
        scan(8'h28, 1'b1, 8'h00, 1, 32'h7);
        scan(8'h2c, 1'b1, 8'h00, 1, 32'h8);
        scan(8'h98, 1'b1, 8'h00, 1, 32'h4);
        scan(8'h20, 1'b1, 8'h00, 1, 32'h6);
        // auto-scan with the first input disabled and a slow converter
        seen.delete();
        aux_input_one_en = 1'b0;
        conv_lat = 4'h6;
        wreg(8'h24);
        pulse(host_start);
        k = 0;
        while (seen.size() < 3 && k < 200) begin
            cyc(1);
            k++;
        end
        if (k >= 200) begin
            n_fail++;
            test_done;
        end
        sar_stop = 1'b1;
        cyc(3);
        chk({7'h0, scan_busy}, 8'h00);
        chk({7'h0, adc_power_down}, 8'h01);
        cyc(20);
        chk(8'(seen.size()), 8'h03);
        chk({4'h0, seen[0]}, 8'h05);
        chk({4'h0, seen[1]}, 8'h06);
        chk({4'h0, seen[2]}, 8'h05);
        sar_stop = 1'b0;
        // all inputs enabled now, so the loop back to aux one is seen
        aux_input_one_en = 1'b1;
        conv_lat = 4'h2;
        cyc(2);
        chk({7'h0, adc_power_down}, 8'h00);
        seen.delete();
        pulse(host_start);
        cyc(4);
        chk({7'h0, scan_busy}, 8'h01);
        cyc(14);
        chk(8'(seen.size()), 8'h04);
        chk({4'h0, seen[0]}, 8'h04);
        chk({4'h0, seen[2]}, 8'h06);
        chk({4'h0, seen[3]}, 8'h04);
        wreg(8'h00);
        chk({7'h0, scan_busy}, 8'h00);
        // interrupt pin routing
        pulse(result_read);
        cyc(2);
        touch = 1'b1;
        cyc(5);
        chk({7'h0, irq_pin}, 8'h00);
        touch = 1'b0;
        cyc(5);
        chk({7'h0, irq_pin}, 8'h01);
        scan(8'h1d, 1'b1, 8'h00, 1, 32'h5);
        chk({7'h0, irq_pin}, 8'h00);
        wreg(8'h1e);
        cyc(2);
        chk({7'h0, irq_pin}, 8'h01);
        pulse(result_read);
        cyc(3);
        chk({7'h0, irq_pin}, 8'h00);
        touch = 1'b1;
        cyc(5);
        chk({7'h0, irq_pin}, 8'h01);
        touch = 1'b0;
        cyc(2);
        test_done;
    end
endmodule
